// ---- wdrc_consts.svh ----
// Offsets, field positions, reset values and timing counts of the watchdog block.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef WDRC_CONSTS_SVH
`define WDRC_CONSTS_SVH

`define WDRC_ADDR_W 12
`define WDRC_CTRL_OFF 12'h060
`define WDRC_CAUSE_OFF 12'h064

`define WDRC_CTRL_IRQ_FLAG 7
`define WDRC_CTRL_IRQ_EN 6
`define WDRC_CTRL_PERIOD_HI 5
`define WDRC_CTRL_UNLOCK 4
`define WDRC_CTRL_RST_EN 3
`define WDRC_CTRL_PERIOD_LO 0

`define WDRC_CAUSE_JTAG 4
`define WDRC_CAUSE_GUARD 3
`define WDRC_CAUSE_BROWNOUT 2
`define WDRC_CAUSE_PIN 1
`define WDRC_CAUSE_POR 0
`define WDRC_CAUSE_BITS 5
`define WDRC_CAUSE_RESET 5'h01

`define WDRC_OSC_KHZ 128
`define WDRC_TMO_MIN_MS 16
`define WDRC_MAX_CODE 4'h9
`define WDRC_UNLOCK_CYCLES 3'h4

`endif

// ---- wdrc_pkg.sv ----
// Types shared by the watchdog block.
// Uses no macros from the constants header and does not include it.
package wdrc_pkg;
	typedef enum logic [1:0] {
		WDRC_MODE_STOP = 2'b00,
		WDRC_MODE_IRQ = 2'b01,
		WDRC_MODE_RESET = 2'b10,
		WDRC_MODE_BOTH = 2'b11
	} wdrc_mode_t;
	typedef logic [3:0] wdrc_period_t;
endpackage

// ---- wdrc_top.sv ----
// Watchdog timer with reset-cause flags, reached over APB.
// Assumes an APB master on pclk; the 128 kHz oscillator arrives as a plain input.
// Summary of operation
// - Counter advances on independent 128 kHz oscillator cycles.
// - Missed restart raises interrupt or reset per mode.
// - Interrupt mode requests interrupt that can wake.
// - Programmed fuse forces reset enable, no interrupt.
// - Period changes and reset-enable clears accepted only within four cycles after unlock.
// - Four period bits select 16ms to 8s.
// - JTAG reset sets bit 4, cleared by zero.
// - Guard, brownout, pin flags set on their resets.
// - Power-on flag set at power-on, zero-write clears.
// - Time-out in interrupt configuration sets flag bit 7.
// - Vector execution or one-write clears interrupt flag.
// - Interrupt taken only with both enables set.
// - Vector in combined mode clears enable and flag.
// - Unserviced combined-mode interrupt then resets next time-out.
// - Mode decodes from the two enables and fuse.
// - Guard reset flag forces reset enable high.
// - Change bit clears itself four cycles later.
// - Reset time-out gives one-cycle reset pulse.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "wdrc_consts.svh"

module wdrc_top #(
	parameter int CNT_W = 20,
	parameter int BASE_CYCLES = `WDRC_TMO_MIN_MS * `WDRC_OSC_KHZ
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [`WDRC_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Watchdog oscillator and fuse
	input wire logic osc_clk,
	input wire logic always_on_fuse_n,
	// CPU side
	input wire logic restart_req,
	input wire logic global_irq_en,
	input wire logic irq_vector_ack,
	// Other reset sources, one pulse each
	input wire logic jtag_reset_evt,
	input wire logic brownout_reset_evt,
	input wire logic pin_reset_evt,
	// Results
	output logic timeout_irq_req,
	output logic wake_req,
	output logic sys_reset_pulse
);
	logic access;
	logic hit_ctrl;
	logic hit_cause;
	logic wr_ctrl;
	logic wr_cause;
	logic [7:0] wd;
	logic unlock_wr;
	logic change_wr;
	logic unlock_bit;
	logic fuse_prog;
	logic rst_en_eff;
	logic irq_en_eff;
	logic expire;
	logic do_reset;
	logic set_flag;
	logic clr_flag;
	logic [CNT_W-1:0] limit_m1;
	wdrc_pkg::wdrc_period_t code_eff;
	wdrc_pkg::wdrc_mode_t mode;
	logic [`WDRC_CAUSE_BITS-1:0] cause_ev;
	logic [`WDRC_CAUSE_BITS-1:0] cause_r;
	logic irq_flag_r;
	logic irq_en_r;
	logic rst_en_r;
	wdrc_pkg::wdrc_period_t period_r;
	logic [2:0] unlock_cnt_r;
	logic [CNT_W-1:0] cnt_r;
	logic osc_s1_r;
	logic osc_s2_r;
	logic osc_s3_r;
	logic osc_tick;
	logic rst_pulse_r;
	logic [31:0] prdata_r;
	logic [7:0] ctrl_view;

	// Zero wait states: every access completes in its first access cycle
	assign access = psel & penable;
	assign hit_ctrl = paddr == `WDRC_CTRL_OFF;
	assign hit_cause = paddr == `WDRC_CAUSE_OFF;
	assign wd = pwdata[7:0];
	assign wr_ctrl = access & pwrite & hit_ctrl & pstrb[0];
	assign wr_cause = access & pwrite & hit_cause & pstrb[0];
	assign pready = 1'b1;
	assign pslverr = access & ~(hit_ctrl | hit_cause);
	assign prdata = prdata_r;

	assign fuse_prog = ~always_on_fuse_n;
	assign rst_en_eff = rst_en_r | cause_r[`WDRC_CAUSE_GUARD] | fuse_prog;
	assign irq_en_eff = irq_en_r & ~fuse_prog;

	always_comb
	begin
		case ({rst_en_eff, irq_en_eff})
			2'b00: mode = wdrc_pkg::WDRC_MODE_STOP;
			2'b01: mode = wdrc_pkg::WDRC_MODE_IRQ;
			2'b10: mode = wdrc_pkg::WDRC_MODE_RESET;
			2'b11: mode = wdrc_pkg::WDRC_MODE_BOTH;
			default: mode = wdrc_pkg::WDRC_MODE_RESET;
		endcase
	end

	// Timed unlock sequence
	assign unlock_bit = unlock_cnt_r != 3'h0;
	assign unlock_wr = wr_ctrl & wd[`WDRC_CTRL_UNLOCK] & wd[`WDRC_CTRL_RST_EN];
	assign change_wr = wr_ctrl & ~wd[`WDRC_CTRL_UNLOCK] & unlock_bit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			unlock_cnt_r <= 3'h0;
		else if (unlock_wr)
			unlock_cnt_r <= `WDRC_UNLOCK_CYCLES;
		else if (wr_ctrl & ~wd[`WDRC_CTRL_UNLOCK])
			unlock_cnt_r <= 3'h0;
		else if (unlock_bit)
			unlock_cnt_r <= unlock_cnt_r - 3'h1;
	end

	// Setting the reset enable is always allowed; clearing needs the unlock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rst_en_r <= 1'b0;
		else if (change_wr)
			rst_en_r <= wd[`WDRC_CTRL_RST_EN];
		else if (wr_ctrl & wd[`WDRC_CTRL_RST_EN])
			rst_en_r <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_r <= 4'h0;
		else if (change_wr)
			period_r <= {wd[`WDRC_CTRL_PERIOD_HI], wd[`WDRC_CTRL_PERIOD_LO +: 3]};
	end

	// A software write in the vector cycle wins, so a re-arm is never lost
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_en_r <= 1'b0;
		else if (wr_ctrl)
			irq_en_r <= wd[`WDRC_CTRL_IRQ_EN] & ~fuse_prog;
		else if (irq_vector_ack & rst_en_eff)
			irq_en_r <= 1'b0;
	end

	// Oscillator sampled into pclk; first stage read only by the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end
		else
		begin
			osc_s1_r <= osc_clk;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end
	assign osc_tick = osc_s2_r & ~osc_s3_r;

	// Reserved codes behave as the longest period
	assign code_eff = (period_r > `WDRC_MAX_CODE) ? `WDRC_MAX_CODE : period_r;
	assign limit_m1 = CNT_W'((BASE_CYCLES << code_eff) - 1);
	// Compare with >= so a shorter period set late expires on the next oscillator tick
	assign expire = osc_tick & ~restart_req & (mode != wdrc_pkg::WDRC_MODE_STOP)
		& (cnt_r >= limit_m1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= '0;
		else if (restart_req || mode == wdrc_pkg::WDRC_MODE_STOP)
			cnt_r <= '0;
		else if (expire)
			cnt_r <= '0;
		else if (osc_tick)
			cnt_r <= cnt_r + 1'b1;
	end

	assign do_reset = expire & ((mode == wdrc_pkg::WDRC_MODE_RESET)
		| ((mode == wdrc_pkg::WDRC_MODE_BOTH) & irq_flag_r));
	assign set_flag = expire & ((mode == wdrc_pkg::WDRC_MODE_IRQ)
		| ((mode == wdrc_pkg::WDRC_MODE_BOTH) & ~irq_flag_r));
	assign clr_flag = irq_vector_ack | (wr_ctrl & wd[`WDRC_CTRL_IRQ_FLAG]);

	// Set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_flag_r <= 1'b0;
		else
			irq_flag_r <= set_flag | (irq_flag_r & ~clr_flag);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rst_pulse_r <= 1'b0;
		else
			rst_pulse_r <= do_reset;
	end
	assign sys_reset_pulse = rst_pulse_r;

	assign wake_req = irq_flag_r & irq_en_eff;
	assign timeout_irq_req = wake_req & global_irq_en;

	// Reset-cause flags: power-on sets bit 0 through the reset value
	assign cause_ev = {jtag_reset_evt, do_reset, brownout_reset_evt, pin_reset_evt, 1'b0};
	genvar gi;
	generate
		for (gi = 0; gi < `WDRC_CAUSE_BITS; gi++)
		begin : g_cause
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					cause_r[gi] <= 1'(`WDRC_CAUSE_RESET >> gi);
				else
					cause_r[gi] <= cause_ev[gi] | (cause_r[gi] & ~(wr_cause & ~wd[gi]));
			end
		end
	endgenerate

	assign ctrl_view = {irq_flag_r, irq_en_eff, period_r[3], unlock_bit, rst_en_eff, period_r[2:0]};

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0;
		else if (psel & ~penable & ~pwrite)
		begin
			if (hit_ctrl)
				prdata_r <= {24'h0, ctrl_view};
			else if (hit_cause)
				prdata_r <= {27'h0, cause_r};
			else
				prdata_r <= 32'h0;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_pulse_one;
		sys_reset_pulse |=> !sys_reset_pulse;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");

	property p_fuse_force;
		fuse_prog |-> (rst_en_eff && !irq_en_eff && !wake_req);
	endproperty
	a_fuse_force: assert property (p_fuse_force) else $error("fuse not forcing mode");

	property p_guard_enable;
		cause_r[`WDRC_CAUSE_GUARD] |-> ctrl_view[`WDRC_CTRL_RST_EN];
	endproperty
	a_guard_enable: assert property (p_guard_enable) else $error("guard flag not forcing enable");

	property p_unlock_end;
		(unlock_wr ##1 (!unlock_wr)[*4]) |=> !unlock_bit;
	endproperty
	a_unlock_end: assert property (p_unlock_end) else $error("unlock bit outlived window");

	property p_unlock_hold;
		unlock_wr |=> unlock_bit;
	endproperty
	a_unlock_hold: assert property (p_unlock_hold) else $error("unlock bit not set");

	property p_reset_mode;
		(expire && mode == wdrc_pkg::WDRC_MODE_RESET) |=> sys_reset_pulse && cause_r[`WDRC_CAUSE_GUARD];
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("no reset on time-out");

	property p_irq_mode;
		(expire && mode == wdrc_pkg::WDRC_MODE_IRQ) |=> irq_flag_r && !sys_reset_pulse;
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("no flag on time-out");

	property p_both_second;
		(expire && mode == wdrc_pkg::WDRC_MODE_BOTH && irq_flag_r) |=> sys_reset_pulse;
	endproperty
	a_both_second: assert property (p_both_second) else $error("combined mode missed reset");

	property p_vector_clear;
		(irq_vector_ack && rst_en_eff && !wr_ctrl && !set_flag) |=> !irq_en_r && !irq_flag_r;
	endproperty
	a_vector_clear: assert property (p_vector_clear) else $error("vector left enable set");

	property p_period_lock;
		(wr_ctrl && !unlock_bit) |=> $stable(period_r);
	endproperty
	a_period_lock: assert property (p_period_lock) else $error("period changed while locked");

	property p_gie_gate;
		!global_irq_en |-> !timeout_irq_req;
	endproperty
	a_gie_gate: assert property (p_gie_gate) else $error("interrupt without global enable");

	c_both_reset: cover property (expire && mode == wdrc_pkg::WDRC_MODE_BOTH && irq_flag_r);
	c_change: cover property (change_wr && !wd[`WDRC_CTRL_RST_EN]);
	c_irq: cover property (timeout_irq_req ##1 irq_vector_ack);
endmodule

// ---- tb_wdrc_top.sv ----
// Self-checking bench for the watchdog block, driven over APB.
// Assumes the design files and the constants header sit in this folder.
`timescale 1ns/1ps
`include "wdrc_consts.svh"
module tb_wdrc_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_clk = 0;
	logic [`WDRC_ADDR_W-1:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, er, fuse_n = 1, restart_req = 0, gie = 0, ack = 0;
	logic jtag = 0, bor = 0, pin = 0, irq, wake, rst_pulse;
	logic [3:0] c;
	int err_count = 0, samples_checked = 0, osc_div = 0;
	always #4 pclk = ~pclk;
	// Oscillator near 128 kHz, stepped on pclk edges like every other input
	always @(posedge pclk)
	begin
		if (osc_div == 487)
		begin
			osc_div <= 0;
			osc_clk <= ~osc_clk;
		end
		else
			osc_div <= osc_div + 1;
	end
	wdrc_top #(.BASE_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk),
		.always_on_fuse_n(fuse_n), .restart_req(restart_req), .global_irq_en(gie),
		.irq_vector_ack(ack), .jtag_reset_evt(jtag), .brownout_reset_evt(bor),
		.pin_reset_evt(pin), .timeout_irq_req(irq), .wake_req(wake),
		.sys_reset_pulse(rst_pulse));
	function logic [7:0] cb(input logic f, ie, input logic [3:0] p, input logic u, w);
		cb = {f, ie, p[3], u, w, p[2:0]};
	endfunction
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// Upper data bits random: the block must ignore them
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		logic [31:0] r;
		r = $urandom;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {r[31:8], d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			err_count++;
			tally_and_finish;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wait_hi(input bit s);
		int n;
		n = 0;
		while ((s ? rst_pulse : wake) !== 1'b1 && n < 20000)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000)
		begin
			err_count++;
			tally_and_finish;
		end
	endtask
	task pulse_evts(input logic j, b, p);
		@(posedge pclk);
		jtag <= j;
		bor <= b;
		pin <= p;
		@(posedge pclk);
		jtag <= 0;
		bor <= 0;
		pin <= 0;
	endtask
	initial
	begin
		void'($urandom(32'h5538));
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("ctrl reset", 0, rd);
		apb(0, `WDRC_CAUSE_OFF, 0);
		chk("cause reset", `WDRC_CAUSE_RESET, rd);
		apb(0, 12'h0f0, 0);
		chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
		pulse_evts(1, 1, 1);
		apb(0, `WDRC_CAUSE_OFF, 0);
		chk("cause events", 8'h17, rd);
		// Byte lane 0 off: the write must be ignored
		pstrb <= 4'he;
		apb(1, `WDRC_CAUSE_OFF, 8'h00);
		pstrb <= 4'hf;
		apb(0, `WDRC_CAUSE_OFF, 0);
		chk("strobe off", 8'h17, rd);
		apb(1, `WDRC_CAUSE_OFF, 8'h1e);
		apb(0, `WDRC_CAUSE_OFF, 0);
		chk("por zero write", 8'h16, rd);
		apb(1, `WDRC_CAUSE_OFF, 8'h00);
		apb(0, `WDRC_CAUSE_OFF, 0);
		chk("cause cleared", 0, rd);
		// Codes 0 and 9 are the bounds, the rest drawn at random
		for (int i = 0; i < 10; i++)
		begin
			c = (i < 2) ? 4'(i * 9) : 4'($urandom % 10);
			apb(1, `WDRC_CTRL_OFF, 8'h18);
			apb(1, `WDRC_CTRL_OFF, cb(0, 0, c, 0, 0));
			apb(0, `WDRC_CTRL_OFF, 0);
			chk("period", cb(0, 0, c, 0, 0), rd);
		end
		apb(1, `WDRC_CTRL_OFF, 8'h18);
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("unlock open", cb(0, 0, c, 1, 1), rd);
		repeat (6) @(posedge pclk);
		apb(1, `WDRC_CTRL_OFF, 8'h05);
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("window closed", cb(0, 0, c, 0, 1), rd);
		restart_req <= 1;
		@(posedge pclk);
		restart_req <= 0;
		apb(1, `WDRC_CTRL_OFF, 8'h18);
		apb(1, `WDRC_CTRL_OFF, 8'h40);
		repeat (6)
		begin
			repeat (1500) @(posedge pclk);
			restart_req <= 1;
			@(posedge pclk);
			restart_req <= 0;
		end
		chk("restart in time", 0, wake);
		wait_hi(0);
		chk("irq gated", 0, irq);
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("flag set", 8'hc0, rd);
		gie <= 1;
		repeat (2) @(posedge pclk);
		chk("irq taken", 1, irq);
		ack <= 1;
		@(posedge pclk);
		ack <= 0;
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("vector clears", 8'h40, rd);
		wait_hi(0);
		apb(1, `WDRC_CTRL_OFF, 8'hc0);
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("one clears", 8'h40, rd);
		apb(1, `WDRC_CTRL_OFF, 8'h48);
		wait_hi(0);
		ack <= 1;
		@(posedge pclk);
		ack <= 0;
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("vector to reset mode", 8'h08, rd);
		apb(1, `WDRC_CTRL_OFF, 8'h48);
		wait_hi(0);
		wait_hi(1);
		@(posedge pclk);
		chk("pulse width", 0, rst_pulse);
		apb(0, `WDRC_CAUSE_OFF, 0);
		chk("guard flag", 8'h08, rd);
		apb(1, `WDRC_CTRL_OFF, 8'h18);
		apb(1, `WDRC_CTRL_OFF, 8'h00);
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("enable forced", 1, rd[3]);
		apb(1, `WDRC_CAUSE_OFF, 8'h00);
		apb(1, `WDRC_CTRL_OFF, 8'h18);
		apb(1, `WDRC_CTRL_OFF, 8'h80);
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("stopped", 0, rd);
		fuse_n <= 0;
		apb(1, `WDRC_CTRL_OFF, 8'h40);
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("fuse locks", 8'h08, rd);
		chk("fuse no irq", 0, irq);
		wait_hi(1);
		apb(0, `WDRC_CAUSE_OFF, 0);
		chk("fuse reset", 8'h08, rd);
		// Second power-on in mid-run
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, `WDRC_CAUSE_OFF, 0);
		chk("cause after por", `WDRC_CAUSE_RESET, rd);
		apb(0, `WDRC_CTRL_OFF, 0);
		chk("ctrl after por", 8'h08, rd);
		chk("pulse after por", 0, rst_pulse);
		tally_and_finish;
	end
endmodule
